// ===== src/atsp_pkg.sv
// constants, register map and types of the auto transfer serial port
// assumes a byte-wide cpu register port with 32-bit addresses
//
// What this block does
// - shift register write starts transfer when idle
// - writes while disabled never launch later
// - one-byte mode stops clock, pulses done
// - auto mode moves up to 32 bytes
// - disabled: data out low, clock high
// - enable bit low holds unit in reset
// - disabling clears registers and buffer ram
// - buffer ram unreachable while disabled
// - auto mode bit picks one-byte or auto
// - single auto mode stops after end address
// - repeat mode wraps counter to zero
// - master bit drives clock, else slave
// - transmit off: data low, no ram read
// - receive off: no ram write
// - bit order select: msb or lsb first
// - prescaler divides system clock by 1, 2, 4 or 8
// - active flag high from start to end
// - active flag ignores software writes
// - ram writable while transfer active
// - stop trigger ends after current byte
// - start trigger launches, reads one until done
// - shift out on fall, store on rise
// - divisor 6, 8, 16 or 32
// - end pointer holds last address 0..31
package atsp_pkg;
  localparam logic [31:0] ATSP_MODE_ADDR  = 32'hFFFFFD40;
  localparam logic [31:0] ATSP_STAT_ADDR  = 32'hFFFFFD41;
  localparam logic [31:0] ATSP_TRIG_ADDR  = 32'hFFFFFD42;
  localparam logic [31:0] ATSP_DIV_ADDR   = 32'hFFFFFD43;
  localparam logic [31:0] ATSP_END_ADDR   = 32'hFFFFFD44;
  localparam logic [31:0] ATSP_INTV_ADDR  = 32'hFFFFFD45;
  localparam logic [31:0] ATSP_SHIFT_ADDR = 32'hFFFFFD46;
  localparam logic [31:0] ATSP_RAM_BASE   = 32'hFFFFFE00;
  localparam int          ATSP_RAM_WORDS  = 32;
  // mode_control_reg fields
  localparam int ATSP_M_EN     = 7;
  localparam int ATSP_M_AUTO   = 6;
  localparam int ATSP_M_REPEAT = 5;
  localparam int ATSP_M_MASTER = 4;
  localparam int ATSP_M_TXE    = 3;
  localparam int ATSP_M_RXE    = 2;
  localparam int ATSP_M_DIR    = 1;
  localparam logic [7:0] ATSP_MODE_WMASK = 8'hFE;
  // clock_status_reg and trigger_reg fields
  localparam int ATSP_S_CKS_LO = 6;
  localparam int ATSP_S_TSF    = 0;
  localparam int ATSP_T_STA    = 0;
  localparam int ATSP_T_STP    = 1;
  // reset values
  localparam logic [7:0] ATSP_MODE_RST = 8'h00;
  localparam logic [1:0] ATSP_DIV_RST  = 2'h3;
  // master half periods in prescaled ticks for divisors 6, 8, 16, 32
  localparam logic [3:0] ATSP_HALF_6  = 4'h3;
  localparam logic [3:0] ATSP_HALF_8  = 4'h4;
  localparam logic [3:0] ATSP_HALF_16 = 4'h8;
  localparam logic [4:0] ATSP_HALF_32 = 5'h10;
  localparam logic [3:0] ATSP_BITS    = 4'h8;

  typedef enum logic [3:0] {
    ATSP_IDLE  = 4'h1,
    ATSP_LOAD  = 4'h2,
    ATSP_SHIFT = 4'h4,
    ATSP_GAP   = 4'h8
  } atsp_state_e;
endpackage

// ===== src/atsp_serial_port.sv
// three-wire serial port with one-byte and automatic buffer transfer
// assumes cpu strobes and pins; sck and sdi are synchronised here
`timescale 1ns/1ps
`default_nettype none
module atsp_serial_port
  import atsp_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic [31:0] i_addr,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_wdata,
  output var  logic [7:0]  o_rdata,
  output var  logic        o_transfer_done_irq,
  input  wire logic        i_serial_clock_pin,
  output var  logic        o_serial_clock_pin,
  output var  logic        o_serial_clock_oe,
  input  wire logic        i_serial_data_in,
  output var  logic        o_serial_data_out
);

  typedef struct packed {
    logic [7:0]                      mode;
    logic [1:0]                      cks;
    logic                            tsf;
    logic                            trig_sta;
    logic                            trig_stp;
    logic [1:0]                      div;
    logic [4:0]                      endp;
    logic [5:0]                      intv;
    logic [7:0]                      sh;
    logic [ATSP_RAM_WORDS-1:0][7:0]  ram;
    logic [4:0]                      addr;
    atsp_state_e                     st;
    logic                            fin;
    logic [2:0]                      pre_cnt;
    logic [4:0]                      half_cnt;
    logic [3:0]                      bit_cnt;
    logic [6:0]                      gap_cnt;
    logic                            sck;
    logic                            sck_oe;
    logic                            sdo;
    logic                            irq;
    logic [7:0]                      rdata;
    logic                            sck_s1;
    logic                            sck_s2;
    logic                            sck_d;
    logic                            sdi_s1;
    logic                            sdi_s2;
  } atsp_state_s;

  atsp_state_s r_reg;
  atsp_state_s r_next;

  // reverse a byte when lsb first is selected
  function automatic logic [7:0] bit_order(input logic [7:0] d, input logic lsb_first);
    logic [7:0] o;
    o = d;
    if (lsb_first) begin
      for (int k = 0; k < 8; k++) begin
        o[k] = d[7-k];
      end
    end
    return o;
  endfunction

  // half period of the master clock in prescaled ticks
  function automatic logic [4:0] half_len(input logic [1:0] sel);
    logic [4:0] h;
    case (sel)
      2'h0:    h = {1'b0, ATSP_HALF_6};
      2'h1:    h = {1'b0, ATSP_HALF_8};
      2'h2:    h = {1'b0, ATSP_HALF_16};
      default: h = ATSP_HALF_32;
    endcase
    return h;
  endfunction

  logic       wr_mode;
  logic       unit_on;
  logic       lsb;
  logic       tick;
  logic       hp;
  logic       fall;
  logic       rise;
  logic       in_ram;
  logic [4:0] ram_idx;
  logic [7:0] sh_in;
  logic       byte_done;
  logic [2:0] pre_max;
  logic       clk_high;

  always_comb begin
    r_next    = r_reg;
    r_next.irq = 1'b0;
    // two-flop synchronisers, the third stage feeds edge detection
    r_next.sck_s1 = i_serial_clock_pin;
    r_next.sck_s2 = r_reg.sck_s1;
    r_next.sck_d  = r_reg.sck_s2;
    r_next.sdi_s1 = i_serial_data_in;
    r_next.sdi_s2 = r_reg.sdi_s1;
    wr_mode   = i_wr && (i_addr == ATSP_MODE_ADDR);
    in_ram    = (i_addr >= ATSP_RAM_BASE) && (i_addr < ATSP_RAM_BASE + ATSP_RAM_WORDS);
    ram_idx   = i_addr[4:0];
    tick      = 1'b0;
    hp        = 1'b0;
    fall      = 1'b0;
    rise      = 1'b0;
    sh_in     = r_reg.sh;
    byte_done = 1'b0;
    pre_max   = 3'h0;
    clk_high  = 1'b0;
    if (wr_mode) begin
      r_next.mode = i_wdata & ATSP_MODE_WMASK;
    end
    unit_on = r_next.mode[ATSP_M_EN];
    // bit order from the settled mode, not from a same-cycle write
    lsb     = r_reg.mode[ATSP_M_DIR];

    // unit reset is taken at the clock edge rather than from a flop-driven
    // async reset, so a glitch on the enable bit cannot half-clear the state
    if (!unit_on) begin
      // unit held in reset while disabled, ram contents lost
      // clock select cleared on the 1 to 0 step, then written while off
      r_next.cks      = r_reg.mode[ATSP_M_EN] ? 2'h0 : r_reg.cks;
      if (i_wr && i_addr == ATSP_STAT_ADDR) begin
        r_next.cks = i_wdata[ATSP_S_CKS_LO +: 2];
      end
      r_next.tsf      = 1'b0;
      r_next.trig_sta = 1'b0;
      r_next.trig_stp = 1'b0;
      r_next.div      = ATSP_DIV_RST;
      r_next.endp     = 5'h00;
      r_next.intv     = 6'h00;
      r_next.sh       = 8'h00;
      r_next.ram      = '0;
      r_next.addr     = 5'h00;
      r_next.st       = ATSP_IDLE;
      r_next.fin      = 1'b0;
      r_next.pre_cnt  = 3'h0;
      r_next.half_cnt = 5'h00;
      r_next.bit_cnt  = 4'h0;
      r_next.gap_cnt  = 7'h00;
      r_next.sck      = 1'b1;
      r_next.sdo      = 1'b0;
    end else begin
      // prescaler: system clock divided by 1, 2, 4 or 8
      pre_max = 3'((4'h1 << r_reg.cks) - 4'h1);
      tick    = (r_reg.pre_cnt >= pre_max);
      r_next.pre_cnt = tick ? 3'h0 : 3'(r_reg.pre_cnt + 3'h1);

      // master half period from the divisor
      if ((r_reg.st == ATSP_SHIFT || r_reg.st == ATSP_GAP) && tick) begin
        if (r_reg.half_cnt >= 5'(half_len(r_reg.div) - 5'h01)) begin
          r_next.half_cnt = 5'h00;
          hp = 1'b1;
        end else begin
          r_next.half_cnt = 5'(r_reg.half_cnt + 5'h01);
        end
      end

      // clock edges: own clock in master, synced pin in slave
      if (r_reg.mode[ATSP_M_MASTER]) begin
        fall = hp && (r_reg.st == ATSP_SHIFT) && r_reg.sck;
        rise = hp && (r_reg.st == ATSP_SHIFT) && !r_reg.sck;
      end else begin
        fall = (r_reg.st == ATSP_SHIFT) && r_reg.sck_d && !r_reg.sck_s2;
        rise = (r_reg.st == ATSP_SHIFT) && !r_reg.sck_d && r_reg.sck_s2;
      end

      // register writes; active flag has no write path
      if (i_wr && i_addr == ATSP_STAT_ADDR) begin
        r_next.cks = i_wdata[ATSP_S_CKS_LO +: 2];
      end
      if (i_wr && i_addr == ATSP_DIV_ADDR) begin
        r_next.div = i_wdata[1:0];
      end
      if (i_wr && i_addr == ATSP_END_ADDR) begin
        r_next.endp = i_wdata[4:0];
      end
      if (i_wr && i_addr == ATSP_INTV_ADDR) begin
        r_next.intv = i_wdata[5:0];
      end
      // buffer ram stays writable during transfer
      if (i_wr && in_ram) begin
        r_next.ram[ram_idx] = i_wdata;
      end

      // launch needs the clock at rest high: own clock or synced pin
      clk_high = r_reg.mode[ATSP_M_MASTER] ? r_reg.sck : r_reg.sck_s2;
      // one-byte start by writing the shift register
      if (i_wr && i_addr == ATSP_SHIFT_ADDR && r_reg.mode[ATSP_M_EN] && !r_reg.mode[ATSP_M_AUTO]
          && r_reg.st == ATSP_IDLE && clk_high) begin
        r_next.sh       = bit_order(i_wdata, lsb);
        r_next.st       = ATSP_SHIFT;
        r_next.tsf      = 1'b1;
        r_next.bit_cnt  = 4'h0;
        r_next.half_cnt = 5'h00;
      end

      // trigger writes honoured only in auto mode
      if (i_wr && i_addr == ATSP_TRIG_ADDR && r_reg.mode[ATSP_M_AUTO]) begin
        if (i_wdata[ATSP_T_STA] && r_reg.st == ATSP_IDLE) begin
          r_next.trig_sta = 1'b1;
          r_next.tsf      = 1'b1;
          r_next.addr     = 5'h00;
          r_next.st       = ATSP_LOAD;
          r_next.fin      = 1'b0;
          r_next.trig_stp = 1'b0;
        end
        if (i_wdata[ATSP_T_STP] && r_reg.st != ATSP_IDLE) begin
          r_next.trig_stp = 1'b1;
        end
      end

      // fetch next byte; no ram read with transmit off
      if (r_reg.st == ATSP_LOAD) begin
        r_next.sh       = r_reg.mode[ATSP_M_TXE] ? bit_order(r_reg.ram[r_reg.addr], lsb) : 8'h00;
        r_next.st       = ATSP_SHIFT;
        r_next.bit_cnt  = 4'h0;
        r_next.half_cnt = 5'h00;
      end

      // shift out on fall, store sampled bit on rise
      if (fall) begin
        r_next.sdo = r_reg.sh[7];
        if (r_reg.mode[ATSP_M_MASTER]) begin
          r_next.sck = 1'b0;
        end
      end
      if (rise) begin
        sh_in       = {r_reg.sh[6:0], r_reg.sdi_s2};
        r_next.sh   = sh_in;
        r_next.bit_cnt = 4'(r_reg.bit_cnt + 4'h1);
        if (r_reg.mode[ATSP_M_MASTER]) begin
          r_next.sck = 1'b1;
        end
        byte_done = (r_reg.bit_cnt == ATSP_BITS - 4'h1);
      end

      // end of a byte: store, step counter, choose stop or go on
      if (byte_done) begin
        r_next.gap_cnt  = r_reg.mode[ATSP_M_MASTER] ? {r_reg.intv, 1'b0} : 7'h00;
        r_next.half_cnt = 5'h00;
        r_next.st       = ATSP_GAP;
        if (!r_reg.mode[ATSP_M_AUTO]) begin
          r_next.fin = 1'b1;
        end else begin
          if (r_reg.mode[ATSP_M_RXE]) begin
            r_next.ram[r_reg.addr] = bit_order(sh_in, lsb);
          end
          if (r_reg.trig_stp || r_next.trig_stp) begin
            r_next.fin = 1'b1;
          end else if (r_reg.addr == r_reg.endp) begin
            if (r_reg.mode[ATSP_M_REPEAT]) begin
              r_next.addr = 5'h00;
            end else begin
              r_next.fin = 1'b1;
            end
          end else begin
            r_next.addr = 5'(r_reg.addr + 5'h01);
          end
        end
      end

      // byte interval then either next byte or completion
      if (r_reg.st == ATSP_GAP) begin
        if (r_reg.gap_cnt == 7'h00) begin
          if (r_reg.fin) begin
            r_next.st       = ATSP_IDLE;
            r_next.fin      = 1'b0;
            r_next.tsf      = 1'b0;
            r_next.trig_sta = 1'b0;
            r_next.trig_stp = 1'b0;
            r_next.irq      = 1'b1;
          end else begin
            r_next.st = ATSP_LOAD;
          end
        end else if (hp) begin
          r_next.gap_cnt = 7'(r_reg.gap_cnt - 7'h01);
        end
      end

      // master idles high, slave leaves clock to partner
      if (!r_next.mode[ATSP_M_MASTER]) begin
        r_next.sck = 1'b1;
      end
      // transmit off keeps data low
      if (!r_next.mode[ATSP_M_TXE]) begin
        r_next.sdo = 1'b0;
      end
    end
    // clock pin driven only by an enabled master
    r_next.sck_oe = unit_on && r_next.mode[ATSP_M_MASTER];

    // registered read data; ram reads zero while disabled
    r_next.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        ATSP_MODE_ADDR:  r_next.rdata = r_reg.mode;
        ATSP_STAT_ADDR:  r_next.rdata = {r_reg.cks, 5'h00, r_reg.tsf};
        ATSP_TRIG_ADDR:  r_next.rdata = {6'h00, r_reg.trig_stp, r_reg.trig_sta};
        ATSP_DIV_ADDR:   r_next.rdata = {6'h00, r_reg.div};
        ATSP_END_ADDR:   r_next.rdata = {3'h0, r_reg.endp};
        ATSP_INTV_ADDR:  r_next.rdata = {2'h0, r_reg.intv};
        ATSP_SHIFT_ADDR: r_next.rdata = bit_order(r_reg.sh, lsb);
        default: begin
          if (in_ram && r_reg.mode[ATSP_M_EN]) begin
            r_next.rdata = r_reg.ram[ram_idx];
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r_reg          <= '0;
      r_reg.mode     <= ATSP_MODE_RST;
      r_reg.div      <= ATSP_DIV_RST;
      r_reg.st       <= ATSP_IDLE;
      r_reg.sck      <= 1'b1;
      r_reg.sck_s1   <= 1'b1;
      r_reg.sck_s2   <= 1'b1;
      r_reg.sck_d    <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign o_rdata             = r_reg.rdata;
  assign o_transfer_done_irq = r_reg.irq;
  assign o_serial_clock_pin  = r_reg.sck;
  assign o_serial_clock_oe   = r_reg.sck_oe;
  assign o_serial_data_out   = r_reg.sdo;

endmodule
`default_nettype wire

// ===== verif/atsp_partner.sv
// far-side serial slave model shifting a preset pattern
// assumes the port masters the clock, or is clocked from here in slave runs
`timescale 1ns/1ps
`default_nettype none
module atsp_partner (
  input  wire logic        i_sck,
  input  wire logic        i_sdo,
  input  wire logic        i_load,
  input  wire logic [31:0] i_tx,
  output var  logic        o_sck,
  output var  logic        o_sdi,
  output var  logic [31:0] o_rx
);
  logic [31:0] tx_reg;
  initial o_sdi = 1'b0;
  initial o_sck = 1'b1;
  // clock source for slave runs: eight pulses, idle high, off the system edges
  task automatic clock_byte(input int half_ns);
    #10;
    repeat (8) begin
      #(half_ns) o_sck = 1'b0;
      #(half_ns) o_sck = 1'b1;
    end
  endtask
  // next bit leaves on each falling clock, msb first; the sent bit re-enters inverted at the bottom
  always @(negedge i_sck or posedge i_load) begin
    if (i_load) begin
      tx_reg <= i_tx;
    end else begin
      o_sdi  <= tx_reg[31];
      tx_reg <= {tx_reg[30:0], ~tx_reg[31]};
    end
  end
  // port data is taken on each rising clock
  always @(posedge i_sck or posedge i_load) begin
    if (i_load) begin
      o_rx <= '0;
    end else begin
      o_rx <= {o_rx[30:0], i_sdo};
    end
  end
endmodule
`default_nettype wire

// ===== verif/atsp_serial_port_assertions.sv
// pin and bus checker of the auto transfer serial port
// assumes it is bound to atsp_serial_port
`timescale 1ns/1ps
`default_nettype none
module atsp_serial_port_assertions
  import atsp_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_rst_b,
  input wire logic [31:0] i_addr,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  i_wdata,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_transfer_done_irq,
  input wire logic        i_serial_clock_pin,
  input wire logic        o_serial_clock_pin,
  input wire logic        o_serial_clock_oe,
  input wire logic        i_serial_data_in,
  input wire logic        o_serial_data_out
);
  logic en_reg;
  logic mst_reg;
  logic txe_reg;
  // shadow of the enable, master and transmit bits
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_reg  <= 1'b0;
      mst_reg <= 1'b0;
      txe_reg <= 1'b0;
    end else if (i_wr && i_addr == ATSP_MODE_ADDR) begin
      en_reg  <= i_wdata[ATSP_M_EN];
      mst_reg <= i_wdata[ATSP_M_MASTER];
      txe_reg <= i_wdata[ATSP_M_TXE];
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  AST_OFF_PINS: assert property ((!en_reg)[*4] |-> o_serial_clock_pin && !o_serial_data_out)
    else $error("pins not idle while disabled");
  AST_OFF_QUIET: assert property ((!en_reg)[*4] |-> !o_transfer_done_irq && !o_serial_clock_oe)
    else $error("unit active while disabled");
  AST_SLAVE_OE: assert property ((!mst_reg)[*4] |-> !o_serial_clock_oe)
    else $error("clock driven in slave mode");
  AST_MASTER_OE: assert property ((en_reg && mst_reg)[*4] |-> o_serial_clock_oe)
    else $error("clock not driven in master mode");
  AST_TX_LOW: assert property ((!txe_reg)[*4] |-> !o_serial_data_out)
    else $error("data out high with transmit off");
  AST_SDO_ON_FALL: assert property (en_reg && txe_reg && $past(en_reg && txe_reg) && o_serial_clock_oe
    && $changed(o_serial_data_out) |-> $fell(o_serial_clock_pin)) else $error("data out moved off a falling clock");
  AST_LOW_HOLD: assert property (o_serial_clock_oe && $fell(o_serial_clock_pin) |-> !o_serial_clock_pin[*3])
    else $error("clock low phase too short");
  AST_HIGH_HOLD: assert property (o_serial_clock_oe && $rose(o_serial_clock_pin) |-> o_serial_clock_pin[*3])
    else $error("clock high phase too short");
  AST_IRQ_PULSE: assert property (o_transfer_done_irq |=> !o_transfer_done_irq)
    else $error("done pulse longer than one cycle");
  AST_IRQ_SCK_HIGH: assert property (o_transfer_done_irq |-> o_serial_clock_pin)
    else $error("done raised with clock low");
  COV_IRQ: cover property (o_transfer_done_irq);
  COV_FALL: cover property (o_serial_clock_oe && $fell(o_serial_clock_pin));
  COV_RAM_RD: cover property (i_rd && i_addr == ATSP_RAM_BASE);
endmodule
bind atsp_serial_port atsp_serial_port_assertions chk_u (.i_clk_sys, .i_rst_b, .i_addr, .i_wr, .i_rd, .i_wdata,
  .o_rdata, .o_transfer_done_irq, .i_serial_clock_pin, .o_serial_clock_pin, .o_serial_clock_oe,
  .i_serial_data_in, .o_serial_data_out);
`default_nettype wire

// ===== verif/atsp_serial_port_test.sv
// self-checking bench of the auto transfer serial port
// assumes the partner model sits on the three serial wires
`timescale 1ns/1ps
`default_nettype none
module atsp_serial_port_test;
  import atsp_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [31:0] addr = '0;
  logic        wr_s = 1'b0;
  logic        rd = 1'b0;
  logic        pload = 1'b0;
  logic [7:0]  wdata = '0;
  logic [31:0] ptx = '0;
  logic [31:0] prx;
  logic [7:0]  rdata;
  logic        irq, sck_o, oe, sdo, sdi;
  int          fails = 0, tests_run = 0, cyc = 0, nfall = 0, nirq = 0;
  logic        psck;
  wire logic   sck_pin = oe ? sck_o : psck; // partner clock, idle high, when undriven
  atsp_serial_port dut_u (.i_clk_sys(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wr(wr_s), .i_rd(rd),
    .i_wdata(wdata), .o_rdata(rdata), .o_transfer_done_irq(irq), .i_serial_clock_pin(sck_pin),
    .o_serial_clock_pin(sck_o), .o_serial_clock_oe(oe), .i_serial_data_in(sdi), .o_serial_data_out(sdo));
  atsp_partner part_u (.i_sck(sck_pin), .i_sdo(sdo), .i_load(pload), .i_tx(ptx), .o_sck(psck),
    .o_sdi(sdi), .o_rx(prx));
  // clock, falling clock count, done count and watchdog
  always #12.5 clk = ~clk;
  always @(negedge sck_pin) nfall++;
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1) nirq++;
    if (cyc == 60000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic wait_irq(input int lim);
    int n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < lim, 1);
    @(posedge clk);
  endtask
  task automatic pset(input logic [31:0] v);
    ptx <= v;
    pload <= 1'b1;
    @(posedge clk);
    pload <= 1'b0;
    @(posedge clk);
  endtask
  task automatic setup(input logic [7:0] s, input logic [7:0] dv, input logic [7:0] m);
    wr(ATSP_MODE_ADDR, 8'h00);
    wr(ATSP_STAT_ADDR, s);
    wr(ATSP_MODE_ADDR, m);
    wr(ATSP_DIV_ADDR, dv);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    rev = {<<{v}};
  endfunction
  // reset values, read-only flag and an unmapped place
  task automatic t_regs();
    rdchk(ATSP_MODE_ADDR, 8'h00);
    wr(ATSP_STAT_ADDR, 8'h01);
    rdchk(ATSP_STAT_ADDR, 8'h00);
    rdchk(ATSP_TRIG_ADDR, 8'h00);
    rdchk(32'hFFFFFD4F, 8'h00);
  endtask
  // writes while disabled must leave no trace
  task automatic t_off();
    int f0 = nfall;
    wr(ATSP_SHIFT_ADDR, 8'hA5);
    wr(ATSP_RAM_BASE, 8'h3C);
    wr(ATSP_MODE_ADDR, 8'h98);
    repeat (200) @(posedge clk);
    chk(nfall - f0, 0);
    rdchk(ATSP_DIV_ADDR, 8'h03);
    rdchk(ATSP_RAM_BASE, 8'h00);
  endtask
  // one byte each way, then a second launch straight after done
  task automatic t_byte(input logic d, input logic [7:0] b, input logic [7:0] pb);
    int f0;
    setup(8'h00, 8'h00, 8'h9C | {6'h00, d, 1'b0});
    pset({pb, 24'h000000});
    f0 = nfall;
    wr(ATSP_SHIFT_ADDR, b);
    rdchk(ATSP_STAT_ADDR, 8'h01);
    wait_irq(1000);
    chk(nfall - f0, 8);
    chk(prx[7:0], d ? rev(b) : b);
    rdchk(ATSP_SHIFT_ADDR, d ? rev(pb) : pb);
    rdchk(ATSP_STAT_ADDR, 8'h00);
    wr(ATSP_SHIFT_ADDR, ~b);
    wait_irq(1000);
    chk(nfall - f0, 16);
  endtask
  // prescaler and divisor set the clock low phase
  task automatic t_rate(input int k);
    int n = 0;
    int h[4] = '{3, 4, 8, 16};
    setup({k[1:0], 6'h00}, {6'h00, k[1:0]}, 8'h94);
    rdchk(ATSP_STAT_ADDR, {k[1:0], 6'h00});
    wr(ATSP_SHIFT_ADDR, 8'h00);
    @(negedge sck_pin);
    while (sck_pin !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, h[k] << k);
    wait_irq(5000);
  endtask
  // three-byte single automatic run, receive on or off
  task automatic t_auto(input logic [7:0] m);
    int f0;
    int i0;
    setup(8'h00, 8'h00, m);
    rdchk(ATSP_RAM_BASE + 2, 8'h00);
    wr(ATSP_END_ADDR, 8'h02);
    for (int k = 0; k < 3; k++) wr(ATSP_RAM_BASE + k, 8'h11 << k);
    pset(32'h0F1E3C00);
    f0 = nfall;
    i0 = nirq;
    wr(ATSP_TRIG_ADDR, 8'h01);
    rdchk(ATSP_TRIG_ADDR, 8'h01);
    wr(ATSP_RAM_BASE + 5, 8'h77);
    rdchk(ATSP_STAT_ADDR, 8'h01);
    wait_irq(2000);
    repeat (200) @(posedge clk);
    chk(nfall - f0, 24);
    chk(nirq - i0, 1);
    chk(prx[23:0], 24'h112244);
    rdchk(ATSP_TRIG_ADDR, 8'h00);
    for (int k = 0; k < 3; k++) rdchk(ATSP_RAM_BASE + k, m[ATSP_M_RXE] ? 8'h0F << k : 8'h11 << k);
    rdchk(ATSP_RAM_BASE + 5, 8'h77);
  endtask
  // repeat run wraps silently until stopped; receive off keeps the ram fixed
  task automatic t_rep();
    int f0;
    int i0;
    int nb;
    setup(8'h00, 8'h00, 8'hF8);
    wr(ATSP_END_ADDR, 8'h01);
    wr(ATSP_RAM_BASE, 8'h5A);
    wr(ATSP_RAM_BASE + 1, 8'hC3);
    f0 = nfall;
    i0 = nirq;
    wr(ATSP_TRIG_ADDR, 8'h01);
    wait (nfall - f0 >= 40);
    @(posedge clk);
    chk(nirq - i0, 0);
    wr(ATSP_TRIG_ADDR, 8'h02);
    wait_irq(2000);
    nb = (nfall - f0) / 8;
    chk(nfall - f0, nb * 8);
    chk(prx[15:0], nb[0] ? 16'hC35A : 16'h5AC3);
    rdchk(ATSP_TRIG_ADDR, 8'h00);
    rdchk(ATSP_STAT_ADDR, 8'h00);
  endtask
  // slave byte clocked by the partner, both directions
  task automatic t_slave();
    int f0;
    setup(8'h00, 8'h00, 8'h8C);
    pset(32'hA7000000);
    f0 = nfall;
    wr(ATSP_SHIFT_ADDR, 8'h3D);
    chk(oe, 1'b0);
    part_u.clock_byte(200);
    wait_irq(100);
    chk(nfall - f0, 8);
    chk(prx[7:0], 8'h3D);
    rdchk(ATSP_SHIFT_ADDR, 8'hA7);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_off();
    t_byte(1'b0, 8'hB4, 8'h6D);
    t_byte(1'b1, 8'hB4, 8'h6D);
    for (int k = 0; k < 4; k++) t_rate(k);
    t_auto(8'hDC);
    t_auto(8'hD8);
    t_rep();
    t_slave();
    results();
  end
endmodule
`default_nettype wire
